// ==== core/trcir_cfg.svh ====
// register offsets, field positions and reset values for the timer reload/compare ir block
`ifndef TRCIR_CFG_SVH
`define TRCIR_CFG_SVH
`define TRCIR_OFF_RELOAD   12'h000
`define TRCIR_OFF_RELOADH  12'h004
`define TRCIR_OFF_CC       12'h008
`define TRCIR_OFF_CCH      12'h00c
`define TRCIR_OFF_CTRL     12'h010
`define TRCIR_OFF_STAT     12'h014
`define TRCIR_RST_BYTE     8'h00
`define TRCIR_RST_WORD     16'h0000
`define TRCIR_BIT_DUAL     0
`define TRCIR_BIT_INFRARED_ENABLE     1
`define TRCIR_BIT_INFRARED_TRANSMIT_SELECT     2
`define TRCIR_BIT_INFRARED_BIT_LEVEL     3
`define TRCIR_BIT_POL      4
`define TRCIR_BIT_ES0      5
`define TRCIR_BIT_ES1      6
`define TRCIR_CTRL_W       7
`define TRCIR_RESP_OKAY    2'b00
`define TRCIR_RESP_SLVERR  2'b10
`endif

// ==== core/trcir_pkg.sv ====
// types shared by the timer reload/compare ir block
`default_nettype none
package trcir_pkg;
   // ir operating mode
   typedef enum logic [2:0] {
      TRCIR_OFF = 3'b001,
      TRCIR_RX  = 3'b010,
      TRCIR_TX  = 3'b100
   } trcir_mode_t;
   // control fields
   typedef struct packed {
      logic [1:0] edge_select;
      logic       alternate_polarity;
      logic       infrared_bit_level;
      logic       infrared_transmit_select;
      logic       infrared_enable;
      logic       dual_byte_select;
   } trcir_ctrl_t;
endpackage
`default_nettype wire

// ==== core/trcir_top.sv ====
// timer reload/compare registers with ir subcarrier modulator and receive sampler
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`include "trcir_cfg.svh"
`default_nettype none
// How it works
// - reload register sixteen bits read write
// - dual mode: reload upper reads zero, writes ignored
// - reload_high register gives reload upper byte
// - capture/compare holds match or captured value
// - dual mode: compare upper reads zero, writes blocked
// - capture_compare_high gives compare upper byte
// - low timer always makes the subcarrier
// - ir enabled: high counter counts subcarrier edges
// - polarity sets idle level and counted edge
// - reload_high sets subcarrier cycles per interval
// - transmit: bit level gates subcarrier onto pin
// - polarity applies only when ir enabled
// - overflow reloads high counter from reload_high
// - transmit disables primary pin receive function
// - receive: compare match latches pin into bit
// - receive: selected pin edges reload high counter
// - enable with transmit select chooses rx/tx
// - bit level reaches pin at next overflow
// - dual_byte_select one selects dual 8-bit
module trcir_top
   import trcir_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // axi4-lite write address and data
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   // axi4-lite write response
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // timer core hooks
   input  wire logic        capture_strobe,
   input  wire logic [15:0] capture_value,
   input  wire logic        subcarrier_raw,
   input  wire logic        timer_alt_out,
   // pins
   input  wire logic        primary_timer_pin,
   input  wire logic        counter_input_pin,
   output var  logic        alternate_timer_pin,
   // high counter to timer core
   output var  logic [7:0]  high_byte_counter,
   output var  logic        high_overflow,
   output var  logic        high_compare_match,
   output var  logic        primary_rx_enable
);

   // registers
   logic [15:0] reload_value_q;          // full reload register
   logic [15:0] capture_compare_value_q; // full capture/compare register
   trcir_ctrl_t ctrl_q;                  // control bits
   trcir_mode_t mode;                    // decoded ir mode
   logic [7:0]  hcnt_q;                  // high byte counter
   logic        gate_q;                  // bit level taken at overflow
   logic        alt_q;                   // pin output flop
   logic        pm_q;                    // primary pin sync stage 1
   logic        ps_q;                    // primary pin synced
   logic        pp_q;                    // primary pin previous
   logic        cm_q;                    // counter pin sync stage 1
   logic        cs_q;                    // counter pin synced
   logic        cp_q;                    // counter pin previous
   logic        sc_q;                    // subcarrier previous
   logic        ovf_q;                   // overflow pulse flop
   logic        match_q;                 // match pulse flop
   logic        rxen_q;                  // primary receive enable flop
   logic        rdy_q;                   // write address and data ready flop
   logic        arr_q;                   // read address ready flop

   // axi state
   logic        aw_q, w_q, bv_q, rv_q;
   logic [11:0] awa_q;
   logic [31:0] wd_q, rd_q;
   logic [3:0]  ws_q;
   logic        bresp_err_q, rresp_err_q;

   // byte merge with strobes
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s, input logic keep_hi);
      logic [15:0] r;
      r = old;
      if (s[0]) r[7:0] = d[7:0];
      if (s[1] && !keep_hi) r[15:8] = d[15:8];
      return r;
   endfunction

   // edge pick by edge_select: 01 rise, 10 fall, 11 both
   function automatic logic edge_hit(input logic cur, input logic prv, input logic [1:0] es);
      return (es[0] && cur && !prv) || (es[1] && !cur && prv);
   endfunction

   // mode decode
   wire dual = ctrl_q.dual_byte_select;
   assign mode = !ctrl_q.infrared_enable ? TRCIR_OFF :
                 ctrl_q.infrared_transmit_select ? TRCIR_TX : TRCIR_RX;

   // high counter input select
   wire sc_edge  = ctrl_q.alternate_polarity ? (subcarrier_raw && !sc_q)
                                              : (!subcarrier_raw && sc_q);
   wire pin_edge = edge_hit(cs_q, cp_q, ctrl_q.edge_select);
   wire cnt_tick = (mode == TRCIR_OFF) ? pin_edge : sc_edge;
   wire ovf      = cnt_tick && (hcnt_q == 8'hff);
   wire rx_sync  = (mode == TRCIR_RX) &&
                   edge_hit(ps_q, pp_q, ctrl_q.edge_select);
   wire match    = (hcnt_q == capture_compare_value_q[15:8]) && cnt_tick;

   // transmit pin: subcarrier shaped by polarity (idle = polarity)
   wire tx_level = gate_q ? (subcarrier_raw ^ ~ctrl_q.alternate_polarity ^ 1'b1)
                          : ctrl_q.alternate_polarity;
   wire alt_d    = (mode == TRCIR_TX) ? tx_level : timer_alt_out;

   // write decode
   wire wr_go  = aw_q && w_q && !bv_q;
   wire wr_ok  = awa_q == `TRCIR_OFF_RELOAD || awa_q == `TRCIR_OFF_RELOADH ||
                 awa_q == `TRCIR_OFF_CC || awa_q == `TRCIR_OFF_CCH ||
                 awa_q == `TRCIR_OFF_CTRL || awa_q == `TRCIR_OFF_STAT;
   wire wr_rl  = wr_go && awa_q == `TRCIR_OFF_RELOAD;
   wire wr_rlh = wr_go && awa_q == `TRCIR_OFF_RELOADH && ws_q[0];
   wire wr_cc  = wr_go && awa_q == `TRCIR_OFF_CC;
   wire wr_cch = wr_go && awa_q == `TRCIR_OFF_CCH && ws_q[0];
   wire wr_ct  = wr_go && awa_q == `TRCIR_OFF_CTRL && ws_q[0];

   // read decode
   wire [31:0] rd_mux =
      (s_axi_araddr == `TRCIR_OFF_RELOAD)  ? {16'h0000, dual ? 8'h00
                                              : reload_value_q[15:8], reload_value_q[7:0]} :
      (s_axi_araddr == `TRCIR_OFF_RELOADH) ? {24'h000000, reload_value_q[15:8]} :
      (s_axi_araddr == `TRCIR_OFF_CC)      ? {16'h0000, dual ? 8'h00
                                              : capture_compare_value_q[15:8],
                                              capture_compare_value_q[7:0]} :
      (s_axi_araddr == `TRCIR_OFF_CCH)     ? {24'h000000, capture_compare_value_q[15:8]} :
      (s_axi_araddr == `TRCIR_OFF_CTRL)    ? {25'h0000000, ctrl_q} :
      (s_axi_araddr == `TRCIR_OFF_STAT)    ? {24'h000000, hcnt_q} : 32'h00000000;
   wire rd_ok = s_axi_araddr == `TRCIR_OFF_RELOAD || s_axi_araddr == `TRCIR_OFF_RELOADH ||
                s_axi_araddr == `TRCIR_OFF_CC || s_axi_araddr == `TRCIR_OFF_CCH ||
                s_axi_araddr == `TRCIR_OFF_CTRL || s_axi_araddr == `TRCIR_OFF_STAT;

   // axi write channel capture and response
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         aw_q        <= 1'b0;
         w_q         <= 1'b0;
         bv_q        <= 1'b0;
         bresp_err_q <= 1'b0;
         rdy_q       <= 1'b0;
         awa_q       <= 12'h000;
         wd_q        <= 32'h00000000;
         ws_q        <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_q && !bv_q) begin
            aw_q  <= 1'b1;
            awa_q <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && !w_q && !bv_q) begin
            w_q  <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         // ready flop: high exactly while both halves are held and no response waits
         rdy_q <= !wr_go && !bv_q && (aw_q || s_axi_awvalid) && (w_q || s_axi_wvalid);
         if (wr_go) begin
            aw_q        <= 1'b0;
            w_q         <= 1'b0;
            bv_q        <= 1'b1;
            bresp_err_q <= !wr_ok;
         end else if (bv_q && s_axi_bready) begin
            bv_q <= 1'b0;
         end
      end
   end

   // read address ready: one-cycle pulse, raised a cycle after arvalid
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         arr_q <= 1'b0;
      else
         arr_q <= s_axi_arvalid && !arr_q && !rv_q;
   end

   // axi read channel: data one cycle after the address handshake
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rv_q        <= 1'b0;
         rd_q        <= 32'h00000000;
         rresp_err_q <= 1'b0;
      end else if (s_axi_arvalid && arr_q) begin
         rv_q        <= 1'b1;
         rd_q        <= rd_mux;
         rresp_err_q <= !rd_ok;
      end else if (rv_q && s_axi_rready) begin
         rv_q <= 1'b0;
      end
   end

   // register file, dual mode masks upper-byte writes at the 16-bit offsets only, not at reload_high or capture_compare_high
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reload_value_q          <= `TRCIR_RST_WORD;
         capture_compare_value_q <= `TRCIR_RST_WORD;
         ctrl_q                  <= '0;
      end else begin
         if (wr_rl)  reload_value_q <= merge16(reload_value_q, wd_q, ws_q, dual);
         if (wr_rlh) reload_value_q[15:8] <= wd_q[7:0];
         if (capture_strobe) begin
            capture_compare_value_q <= dual ? {capture_compare_value_q[15:8],
                                               capture_value[7:0]} : capture_value;
         end else if (wr_cc) begin
            capture_compare_value_q <= merge16(capture_compare_value_q, wd_q, ws_q, dual);
         end else if (wr_cch) begin
            capture_compare_value_q[15:8] <= wd_q[7:0];
         end
         if (wr_ct)
            ctrl_q <= wd_q[`TRCIR_CTRL_W-1:0];
         // a receive sample overrides only the written bit level, not the whole word
         if (mode == TRCIR_RX && match)
            ctrl_q.infrared_bit_level <= ps_q;
      end
   end

   // pin synchronisers and edge history
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pm_q <= 1'b0;
         ps_q <= 1'b0;
         pp_q <= 1'b0;
         cm_q <= 1'b0;
         cs_q <= 1'b0;
         cp_q <= 1'b0;
         sc_q <= 1'b0;
      end else begin
         pm_q <= primary_timer_pin;
         ps_q <= pm_q;
         pp_q <= ps_q;
         cm_q <= counter_input_pin;
         cs_q <= cm_q;
         cp_q <= cs_q;
         sc_q <= subcarrier_raw;
      end
   end

   // high counter with reload from reload_high
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         hcnt_q <= `TRCIR_RST_BYTE;
         gate_q <= 1'b0;
      end else begin
         if (ovf || rx_sync)
            hcnt_q <= reload_value_q[15:8];
         else if (cnt_tick)
            hcnt_q <= hcnt_q + 8'h01;
         if (mode != TRCIR_TX)
            gate_q <= 1'b0;
         else if (ovf)
            gate_q <= ctrl_q.infrared_bit_level;
      end
   end

   // output flops
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         alt_q   <= 1'b0;
         ovf_q   <= 1'b0;
         match_q <= 1'b0;
         rxen_q  <= 1'b1;
      end else begin
         alt_q   <= alt_d;
         ovf_q   <= ovf;
         match_q <= match;
         rxen_q  <= (mode != TRCIR_TX);
      end
   end

   assign s_axi_awready       = rdy_q;
   assign s_axi_wready        = rdy_q;
   assign s_axi_bvalid        = bv_q;
   assign s_axi_bresp         = bresp_err_q ? `TRCIR_RESP_SLVERR : `TRCIR_RESP_OKAY;
   assign s_axi_arready       = arr_q;
   assign s_axi_rvalid        = rv_q;
   assign s_axi_rdata         = rd_q;
   assign s_axi_rresp         = rresp_err_q ? `TRCIR_RESP_SLVERR : `TRCIR_RESP_OKAY;
   assign alternate_timer_pin = alt_q;
   assign high_byte_counter   = hcnt_q;
   assign high_overflow       = ovf_q;
   assign high_compare_match  = match_q;
   assign primary_rx_enable   = rxen_q;

   // checks
   reload_hi_dual_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wr_rl && dual) |=> reload_value_q[15:8] == $past(reload_value_q[15:8]))
      else $error("reload upper byte changed in dual mode");
   cc_hi_dual_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wr_cc && dual && !capture_strobe) |=>
      capture_compare_value_q[15:8] == $past(capture_compare_value_q[15:8]))
      else $error("compare upper byte changed in dual mode");
   reload_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      wr_rlh |=> reload_value_q[15:8] == $past(wd_q[7:0]))
      else $error("reload_high write lost");
   ovf_reload_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ovf |=> hcnt_q == $past(reload_value_q[15:8]))
      else $error("high counter not reloaded on overflow");
   rx_latch_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (mode == TRCIR_RX && match) |=> ctrl_q.infrared_bit_level == $past(ps_q))
      else $error("receive sample not latched");
   tx_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (mode == TRCIR_TX && !gate_q) |=> alternate_timer_pin == $past(ctrl_q.alternate_polarity))
      else $error("transmit pin not idle");
   // the gate may only move at an overflow while transmitting
   gate_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      ($past(mode == TRCIR_TX) && !$past(ovf)) |-> $stable(gate_q))
      else $error("transmit gate changed between overflows");
   off_pass_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (mode == TRCIR_OFF) |=> alternate_timer_pin == $past(timer_alt_out))
      else $error("normal pin path disturbed");
   rx_disable_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (mode == TRCIR_TX) |=> !primary_rx_enable)
      else $error("receive not disabled in transmit");

endmodule
`default_nettype wire

// ==== sim/trcir_ir_partner.sv ====
// external ir receiver output and ir emitter pulse counter
`default_nettype none
module trcir_ir_partner (
   // clock
   input  wire logic        clk_sys,
   // commanded carrier presence and counter clear
   input  wire logic        rx_level,
   input  wire logic        cnt_clr,
   // pins
   output var  logic        primary_timer_pin,
   input  wire logic        alternate_timer_pin,
   // rising edges seen on the emitter
   output var  logic [15:0] tx_edges
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev_q;  // last emitter level
   // receiver drives the pin, the block only listens
   assign primary_timer_pin = rx_level;
   // count emitted pulses
   always @(posedge clk_sys) begin
      prev_q <= alternate_timer_pin;
      if (cnt_clr)
         tx_edges <= 16'h0000;
      else if (alternate_timer_pin && !prev_q)
         tx_edges <= tx_edges + 16'h0001;
   end
endmodule
`default_nettype wire

// ==== sim/tb_timer_reload_compare_ir_modem.sv ====
// self-checking bench for the timer reload/compare ir block
`include "trcir_cfg.svh"
`default_nettype none
module tb_timer_reload_compare_ir_modem;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] a_rl = `TRCIR_OFF_RELOAD;
   localparam logic [11:0] a_rh = `TRCIR_OFF_RELOADH;
   localparam logic [11:0] a_cc = `TRCIR_OFF_CC;
   localparam logic [11:0] a_ch = `TRCIR_OFF_CCH;
   localparam logic [11:0] a_ct = `TRCIR_OFF_CTRL;
   localparam logic [11:0] a_st = `TRCIR_OFF_STAT;
   logic        clk_sys, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, capture_strobe, subcarrier_raw, timer_alt_out, counter_input_pin;
   logic        primary_timer_pin, alternate_timer_pin, high_overflow, high_compare_match;
   logic        primary_rx_enable, rx_level, cnt_clr, sc_run, sc_man;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [15:0] capture_value, tx_edges;
   logic [7:0]  high_byte_counter, v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   bit   [1:0]  div_q;
   int          error_cnt, checks, ov_cnt, o0;
   trcir_top dut (.clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .capture_strobe(capture_strobe), .capture_value(capture_value),
      .subcarrier_raw(subcarrier_raw), .timer_alt_out(timer_alt_out),
      .primary_timer_pin(primary_timer_pin), .counter_input_pin(counter_input_pin),
      .alternate_timer_pin(alternate_timer_pin), .high_byte_counter(high_byte_counter),
      .high_overflow(high_overflow), .high_compare_match(high_compare_match),
      .primary_rx_enable(primary_rx_enable));
   trcir_ir_partner ir (.clk_sys(clk_sys), .rx_level(rx_level), .cnt_clr(cnt_clr),
      .primary_timer_pin(primary_timer_pin), .alternate_timer_pin(alternate_timer_pin),
      .tx_edges(tx_edges));
   // 100 mhz clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // subcarrier stand-in, eight clocks a period
   always @(posedge clk_sys) begin
      div_q <= div_q + 2'h1;
      if (!sc_run)
         subcarrier_raw <= sc_man;
      else if (div_q == 2'h3)
         subcarrier_raw <= ~subcarrier_raw;
   end
   // overflow pulse tally
   always @(posedge clk_sys) begin
      if (high_overflow === 1'b1)
         ov_cnt <= ov_cnt + 1;
   end
   // compare and count
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // axi write, address and data offered together
   task axw(input logic [11:0] a, input logic [31:0] d);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            rsp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
         n++;
      end while (!done && n < 64);
      // one idle edge so the next call never re-drives a strobe in this step
      @(posedge clk_sys);
      chk("write handshake", 32'h1, {31'h0, done});
   endtask
   // axi read
   task axr(input logic [11:0] a);
      int n;
      logic done;
      n = 0;
      done = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
         n++;
      end while (!done && n < 64);
      @(posedge clk_sys);
      chk("read handshake", 32'h1, {31'h0, done});
   endtask
   // read and compare a register
   task rc(input logic [11:0] a, input logic [31:0] e);
      axr(a);
      chk($sformatf("reg %h", a), e, rd);
   endtask
   // wait for a compare match pulse, bounded
   task wm;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (high_compare_match !== 1'b1 && n < 1000);
      chk("match seen", 32'h1, {31'h0, n < 1000});
   endtask
   // verdict and end of run
   task test_done;
      if (error_cnt == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (30000) @(posedge clk_sys);
      error_cnt++;
      test_done;
   end
   // main sequence
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
      s_axi_wstrb = 4'hf;
      {capture_strobe, sc_man, timer_alt_out, counter_input_pin, sc_run} = 5'h00;
      {capture_value, rx_level, error_cnt, checks} = 0;
      resetn = 1'b0;
      cnt_clr = 1'b1;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      cnt_clr <= 1'b0;
      @(posedge clk_sys);
      rc(a_rl, 32'h0);
      rc(a_rh, 32'h0);
      rc(a_cc, 32'h0);
      rc(a_ch, 32'h0);
      axw(a_rl, 32'habcd);
      rc(a_rl, 32'habcd);
      rc(a_rh, 32'hab);
      axw(a_cc, 32'h1357);
      rc(a_cc, 32'h1357);
      rc(a_ch, 32'h13);
      capture_value <= 16'h9876;
      capture_strobe <= 1'b1;
      @(posedge clk_sys);
      capture_strobe <= 1'b0;
      @(posedge clk_sys);
      rc(a_cc, 32'h9876);
      axw(a_ct, 32'h01);
      rc(a_rl, 32'hcd);
      axw(a_rl, 32'h1234);
      rc(a_rl, 32'h34);
      rc(a_rh, 32'hab);
      axw(a_rh, 32'h56);
      rc(a_rh, 32'h56);
      rc(a_cc, 32'h76);
      axw(a_cc, 32'hffee);
      rc(a_cc, 32'hee);
      rc(a_ch, 32'h98);
      axw(a_ch, 32'h42);
      rc(a_ch, 32'h42);
      axw(12'h020, 32'h5);
      chk("unmapped write resp", `TRCIR_RESP_SLVERR, rsp);
      rc(12'h020, 32'h0);
      chk("unmapped read resp", `TRCIR_RESP_SLVERR, rsp);
      timer_alt_out <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("alt pin ir off", 32'h1, alternate_timer_pin);
      axw(a_rh, 32'h0);
      axw(a_ct, 32'h17);
      repeat (4) @(posedge clk_sys);
      chk("alt pin idle high", 32'h1, alternate_timer_pin);
      chk("rx enable in tx", 32'h0, primary_rx_enable);
      axr(a_st);
      v = rd[7:0];
      sc_man <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rc(a_st, {24'h0, v + 8'h01});
      sc_man <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rc(a_st, {24'h0, v + 8'h01});
      axw(a_ct, 32'h07);
      repeat (4) @(posedge clk_sys);
      chk("alt pin idle low", 32'h0, alternate_timer_pin);
      cnt_clr <= 1'b1;
      @(posedge clk_sys);
      cnt_clr <= 1'b0;
      axw(a_ct, 32'h0f);
      repeat (2) begin
         sc_man <= 1'b1;
         repeat (4) @(posedge clk_sys);
         sc_man <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      chk("pulses before overflow", 32'h0, tx_edges);
      axw(a_rh, 32'hfc);
      sc_run <= 1'b1;
      wm;
      repeat (3000) begin
         if (high_overflow !== 1'b1)
            @(posedge clk_sys);
      end
      o0 = ov_cnt;
      repeat (320) @(posedge clk_sys);
      chk("overflow count", 32'h1, {31'h0, ov_cnt - o0 inside {[9:11]}});
      chk("carrier emitted", 32'h1, {31'h0, tx_edges != 16'h0});
      axw(a_ch, 32'hfe);
      rx_level <= 1'b1;
      axw(a_ct, 32'h23);
      chk("rx enable in rx", 32'h1, primary_rx_enable);
      wm;
      wm;
      repeat (4) @(posedge clk_sys);
      rc(a_ct, 32'h2b);
      rx_level <= 1'b0;
      wm;
      wm;
      repeat (4) @(posedge clk_sys);
      rc(a_ct, 32'h23);
      sc_run <= 1'b0;
      axw(a_rh, 32'h10);
      rx_level <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rc(a_st, 32'h10);
      test_done;
   end
endmodule
`default_nettype wire
